// >>> core/tdd_decoder.sv
// Tag downlink decoder: gap bit decoder, frame checker, write controller
`timescale 1ns/1ps
module tdd_decoder
   import tdd_pkg::*;
#(
   parameter int INIT_CYCLES  = INIT_CYC,        // Configuration load time
   parameter int DELAY_CYCLES = PUP_DELAY_CYC,   // Optional start-up delay
   parameter int PROG_CYCLES  = PROG_CYC         // Erase and program time
)
(
   input  wire logic        clock_i,                // System clock
   input  wire logic        rst_i,                  // Power-on reset, async high
   input  wire logic        field_clk_i,            // Field clock from carrier
   input  wire logic        gap_detect_i,           // High while a field gap lasts
   input  wire logic        sync_gap_i,             // High once a gap is start-gap long
   input  wire logic        prog_fault_i,           // Charge pump reports bad cells
   input  wire logic        next_block_i,           // Modulator finished current block
   output logic             downlink_damp_o,        // Coil load for receive mode
   output logic             program_active_o,       // Charge pump enable
   output logic             uplink_active_o,        // Uplink mode entered
   output logic             uplink_start_o,         // Send start bit now (pulse)
   output logic             modulation_enable_o,    // Modulator may drive the load
   output logic [4:0]       block_sel_o,            // Block being transmitted
   output logic [31:0]      block_data_o,           // Data of that block
   output logic             rate_select_flag_o,     // 0: RF/16, 1: RF/32
   output logic             encoding_select_flag_o, // 0: PSK, 1: Manchester
   output logic             init_busy_o             // Initialisation running
);

   // Field clock side state
   typedef struct packed {
      logic [1:0] gap_sync;     // Gap level synchroniser
      logic [1:0] sgap_sync;    // Start gap level synchroniser
      logic [1:0] ready_sync;   // Initialisation done synchroniser
      logic [1:0] ack_sync;     // Frame acknowledge synchroniser
      logic       gap_prev;
      logic       sgap_prev;
      logic       rx;           // Receive mode
      logic [6:0] fc_cnt;       // Field clocks since last gap end
      tdd_frame_s frame;
      logic       req;          // Frame hand-over toggle
   } tdd_link_s;

   // System clock side state
   typedef struct packed {
      logic [1:0]                          rx_sync;
      logic [1:0]                          req_sync;
      logic [1:0]                          fault_sync;
      logic                                rx_prev;   // Receive level one cycle ago
      logic                                ack;
      tdd_state_e                          st;
      logic [TIMER_W-1:0]                  timer;
      logic [4:0]                          addr;
      logic [BLOCK_W-1:0]                  wdata;
      logic                                direct;
      logic [4:0]                          block;
      logic [NUM_BLOCKS-1:0][BLOCK_W-1:0]  mem;
      logic                                damp;
      logic                                prog;
      logic                                uplink;
      logic                                start;
      logic                                mod_en;
      logic [31:0]                         block_data;
      logic                                rate;
      logic                                enc;
      logic                                init_busy;
   } tdd_sys_s;

   tdd_link_s          l_q;
   tdd_link_s          l_d;
   tdd_sys_s           s_q;
   tdd_sys_s           s_d;
   logic               gap_rise;
   logic               gap_fall;
   logic               sgap_rise;
   logic               bit_val;
   logic               bit_ok;
   tdd_cmd_e           cmd;
   logic [1:0]         op;
   logic [4:0]         cmd_addr;
   logic [BLOCK_W-1:0] cmd_data;
   logic [4:0]         limit;
   logic [TIMER_W-1:0] init_end;
   logic [TIMER_W-1:0] prog_end;
   tdd_frame_s         rx_frame;

   // Enter uplink with the start bit pending
   function automatic tdd_sys_s go_uplink(tdd_sys_s s, logic [4:0] blk, logic dir);
      tdd_sys_s r;
      r        = s;
      r.st     = ST_UPLINK;
      r.block  = blk;
      r.direct = dir;
      r.start  = 1'b1;
      return r;
   endfunction

   // Field clock side: gap timing, bit decode, frame assembly
   always_comb
   begin
      l_d = l_q;
      gap_rise = 1'b0;
      gap_fall = 1'b0;
      sgap_rise = 1'b0;
      bit_val = 1'b0;
      bit_ok = 1'b0;
      l_d.gap_sync   = {l_q.gap_sync[0], gap_detect_i};
      l_d.sgap_sync  = {l_q.sgap_sync[0], sync_gap_i};
      l_d.ready_sync = {l_q.ready_sync[0], ~s_q.init_busy};
      l_d.ack_sync   = {l_q.ack_sync[0], s_q.ack};
      l_d.gap_prev   = l_q.gap_sync[1];
      l_d.sgap_prev  = l_q.sgap_sync[1];
      gap_rise  = l_q.gap_sync[1] & ~l_q.gap_prev;
      gap_fall  = ~l_q.gap_sync[1] & l_q.gap_prev;
      sgap_rise = l_q.sgap_sync[1] & ~l_q.sgap_prev;
      if (!l_q.rx)
      begin
         // Start gap only after init, outside receive, last frame taken
         if (sgap_rise && l_q.ready_sync[1] && (l_q.ack_sync[1] == l_q.req))
         begin
            l_d.rx     = 1'b1;
            l_d.fc_cnt = 7'h00;
            l_d.frame  = '0;
         end
      end
      else if (gap_fall)
      begin
         l_d.fc_cnt = 7'h00;
      end
      else if (gap_rise)
      begin
         // Classify the interval that just closed
         if (l_q.fc_cnt >= FC_ZERO_MIN && l_q.fc_cnt <= FC_ZERO_MAX)
         begin
            bit_ok = 1'b1;
         end
         else if (l_q.fc_cnt >= FC_ONE_MIN && l_q.fc_cnt <= FC_ONE_MAX)
         begin
            bit_ok = 1'b1;
            bit_val = 1'b1;
         end
         l_d.frame.bits = {l_q.frame.bits[FRAME_W-2:0], bit_val};
         if (!bit_ok || l_q.frame.count >= LEN_WRITE5)
         begin
            l_d.frame.err = 1'b1;
         end
         if (l_q.frame.count != LEN_SAT)
         begin
            l_d.frame.count = l_q.frame.count + 6'h01;
         end
      end
      else if (!l_q.gap_sync[1])
      begin
         if (l_q.fc_cnt > FC_ONE_MAX)
         begin
            // Carrier too long without a gap: frame is complete
            l_d.rx  = 1'b0;
            l_d.req = ~l_q.req;
         end
         else
         begin
            l_d.fc_cnt = l_q.fc_cnt + 7'h01;
         end
      end
   end

   // Field clock side registers
   always_ff @(posedge field_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         l_q <= '0;
      end
      else
      begin
         l_q <= l_d;
      end
   end

   // Frame decode, held stable by the hand-over toggle
   always_comb
   begin
      rx_frame = l_q.frame;
      cmd = CMD_ERROR;
      op = 2'h0;
      cmd_addr = 5'h00;
      cmd_data = '0;
      unique case (rx_frame.count)
         LEN_RESET:
         begin
            op = rx_frame.bits[1:0];
            if (op == OP_RESET)
            begin
               cmd = CMD_RESET;
            end
         end
         LEN_READ:
         begin
            op = rx_frame.bits[6:5];
            cmd_addr = rx_frame.bits[4:0];
            if (op == OP_ADDR5)
            begin
               cmd = CMD_READ;
            end
         end
         LEN_WRITE3:
         begin
            op = rx_frame.bits[37:36];
            cmd_addr = {2'h0, rx_frame.bits[2:0]};
            cmd_data = rx_frame.bits[35:3];
            if (op == OP_ADDR3)
            begin
               cmd = CMD_WRITE;
            end
         end
         LEN_WRITE5:
         begin
            op = rx_frame.bits[39:38];
            cmd_addr = rx_frame.bits[4:0];
            cmd_data = rx_frame.bits[37:5];
            if (op == OP_ADDR5)
            begin
               cmd = CMD_WRITE;
            end
         end
         default:
         begin
            cmd = CMD_ERROR;
         end
      endcase
      // Reserved test opcode and bit errors fall back to the error path
      if (rx_frame.err || op == OP_TEST)
      begin
         cmd = CMD_ERROR;
      end
   end

   // Configuration fields and timer limits
   assign limit    = s_q.mem[BLOCK_CFG][CFG_LIMIT_HI:CFG_LIMIT_LO];
   assign init_end = s_q.mem[BLOCK_CFG][CFG_DELAY_BIT]
                   ? TIMER_W'(INIT_CYCLES + DELAY_CYCLES - 1)
                   : TIMER_W'(INIT_CYCLES - 1);
   assign prog_end = TIMER_W'(PROG_CYCLES - 1);

   // System side controller
   always_comb
   begin
      s_d = s_q;
      s_d.rx_sync    = {s_q.rx_sync[0], l_q.rx};
      s_d.req_sync   = {s_q.req_sync[0], l_q.req};
      s_d.fault_sync = {s_q.fault_sync[0], prog_fault_i};
      s_d.rx_prev    = s_q.rx_sync[1];
      s_d.start      = 1'b0;
      unique case (s_q.st)
         ST_INIT:
         begin
            // Load configuration, then optional delay
            if (s_q.timer >= init_end)
            begin
               s_d = go_uplink(s_d, (limit == BLOCK_CFG) ? BLOCK_CFG : BLOCK_FIRST, 1'b0);
            end
            else
            begin
               s_d.timer = s_q.timer + TIMER_W'(1);
            end
         end
         ST_UPLINK, ST_SILENT:
         begin
            // Rise of receive, or a frame still unanswered; a receive level that
            // trails the hand-over toggle by a cycle must not re-enter receive
            if ((s_q.rx_sync[1] && !s_q.rx_prev) || (s_q.req_sync[1] != s_q.ack))
            begin
               s_d.st = ST_RECEIVE;
            end
            else if (s_q.st == ST_UPLINK && next_block_i && !s_q.direct)
            begin
               if (limit == BLOCK_CFG)
               begin
                  s_d.block = BLOCK_CFG;
               end
               else if (s_q.block >= limit)
               begin
                  s_d.block = BLOCK_FIRST;
               end
               else
               begin
                  s_d.block = s_q.block + 5'h01;
               end
            end
         end
         ST_RECEIVE:
         begin
            if (s_q.req_sync[1] != s_q.ack)
            begin
               s_d.ack = s_q.req_sync[1];
               s_d.addr = cmd_addr;
               s_d.wdata = cmd_data;
               s_d.timer = '0;
               unique case (cmd)
                  CMD_RESET:
                  begin
                     s_d.st = ST_INIT;
                  end
                  CMD_READ:
                  begin
                     s_d = go_uplink(s_d, cmd_addr, 1'b1);
                  end
                  CMD_WRITE:
                  begin
                     if (s_q.mem[cmd_addr][LOCK_BIT])
                     begin
                        s_d = go_uplink(s_d, cmd_addr, 1'b1);
                     end
                     else
                     begin
                        s_d.st = ST_PROGRAM;
                     end
                  end
                  CMD_ERROR:
                  begin
                     s_d = go_uplink(s_d, BLOCK_FIRST, 1'b0);
                  end
               endcase
            end
         end
         ST_PROGRAM:
         begin
            // All 33 bits go in together; a pump fault corrupts the cells
            if (s_q.timer >= prog_end)
            begin
               s_d.mem[s_q.addr] = s_q.fault_sync[1] ? ~s_q.wdata : s_q.wdata;
               s_d.st = ST_VERIFY;
            end
            else
            begin
               s_d.timer = s_q.timer + TIMER_W'(1);
            end
         end
         ST_VERIFY:
         begin
            if (s_q.mem[s_q.addr] == s_q.wdata)
            begin
               s_d = go_uplink(s_d, s_q.addr, 1'b1);
            end
            else
            begin
               s_d.st = ST_SILENT;
            end
         end
         default:
         begin
            s_d.st = ST_INIT;
         end
      endcase
      // Registered outputs follow the next state; rate and encoding flags follow the configuration block
      s_d.damp      = (s_d.st == ST_RECEIVE);
      s_d.prog      = (s_d.st == ST_PROGRAM);
      s_d.uplink    = (s_d.st == ST_UPLINK);
      s_d.mod_en    = (s_d.st == ST_UPLINK) && !s_q.mem[BLOCK_CFG][CFG_INH_BIT];
      s_d.init_busy = (s_d.st == ST_INIT);
      s_d.block_data = s_q.mem[s_d.block][31:0];
      s_d.rate      = s_q.mem[BLOCK_CFG][CFG_RATE_BIT];
      s_d.enc       = s_q.mem[BLOCK_CFG][CFG_ENC_BIT];
   end

   // System side registers
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s_q <= '0;
         s_q.init_busy <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs straight from registers
   assign downlink_damp_o        = s_q.damp;
   assign program_active_o       = s_q.prog;
   assign uplink_active_o        = s_q.uplink;
   assign uplink_start_o         = s_q.start;
   assign modulation_enable_o    = s_q.mod_en;
   assign block_sel_o            = s_q.block;
   assign block_data_o           = s_q.block_data;
   assign rate_select_flag_o     = s_q.rate;
   assign encoding_select_flag_o = s_q.enc;
   assign init_busy_o            = s_q.init_busy;

endmodule

// >>> core/tdd_pkg.sv
// Constants, types and timing for the tag downlink decoder
package tdd_pkg;

   // System clock period and derived cycle counts
   localparam int CLK_PERIOD_NS  = 10;
   localparam int PROG_TIME_MS   = 18;        // Erase and program time per block
   localparam int PROG_CYC       = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam int INIT_TIME_NS   = 912000;    // Configuration load after any reset
   localparam int INIT_CYC       = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PUP_DELAY_MS   = 64;        // Extra delay when the delay flag is set
   localparam int PUP_DELAY_CYC  = (PUP_DELAY_MS * 1000000) / CLK_PERIOD_NS;
   localparam int TIMER_W        = 24;

   // Field clock windows for bit decoding
   localparam logic [6:0] FC_ZERO_MIN = 7'h10;   // 16
   localparam logic [6:0] FC_ZERO_MAX = 7'h20;   // 32
   localparam logic [6:0] FC_ONE_MIN  = 7'h30;   // 48
   localparam logic [6:0] FC_ONE_MAX  = 7'h40;   // 64

   // Frame lengths in bits
   localparam logic [5:0] LEN_RESET   = 6'h02;
   localparam logic [5:0] LEN_READ    = 6'h07;
   localparam logic [5:0] LEN_WRITE3  = 6'h26;   // 38
   localparam logic [5:0] LEN_WRITE5  = 6'h28;   // 40
   localparam logic [5:0] LEN_SAT     = 6'h3f;
   localparam int         FRAME_W     = 40;

   // Opcodes
   localparam logic [1:0] OP_RESET    = 2'h0;
   localparam logic [1:0] OP_TEST     = 2'h1;
   localparam logic [1:0] OP_ADDR3    = 2'h2;
   localparam logic [1:0] OP_ADDR5    = 2'h3;

   // Memory layout: 32 blocks, each one lock bit over 32 data bits
   localparam int NUM_BLOCKS   = 32;
   localparam int BLOCK_W      = 33;
   localparam int LOCK_BIT     = 32;

   // Configuration block fields (data bit index, first sent bit is bit 31)
   localparam int CFG_DELAY_BIT = 9;
   localparam int CFG_RATE_BIT  = 8;
   localparam int CFG_ENC_BIT   = 7;
   localparam int CFG_INH_BIT   = 6;
   localparam int CFG_LIMIT_HI  = 5;
   localparam int CFG_LIMIT_LO  = 1;
   localparam logic [4:0] BLOCK_CFG   = 5'h00;
   localparam logic [4:0] BLOCK_FIRST = 5'h01;

   // Received frame as handed from the field clock side
   typedef struct packed {
      logic [FRAME_W-1:0] bits;     // Bits in arrival order, newest at bit 0
      logic [5:0]         count;    // Number of bits received
      logic               err;      // Bit error or overflow seen
   } tdd_frame_s;

   // Controller states
   typedef enum logic [2:0] {
      ST_INIT,
      ST_UPLINK,
      ST_RECEIVE,
      ST_PROGRAM,
      ST_VERIFY,
      ST_SILENT
   } tdd_state_e;

   // Decoded command
   typedef enum logic [1:0] {
      CMD_ERROR,
      CMD_RESET,
      CMD_READ,
      CMD_WRITE
   } tdd_cmd_e;

endpackage

// >>> tb/tdd_asserts.sv
// Port checker for the tag downlink decoder
`timescale 1ns/1ps
module tdd_asserts
#(
   parameter int INIT_CYCLES = 20,  // Initialisation length
   parameter int PROG_CYCLES = 30   // Programming length
)
(
   input wire logic       clock_i,             // System clock
   input wire logic       rst_i,               // Reset
   input wire logic       next_block_i,        // Block advance
   input wire logic       downlink_damp_o,     // Receive load
   input wire logic       program_active_o,    // Programming
   input wire logic       uplink_active_o,     // Uplink mode
   input wire logic       uplink_start_o,      // Start bit pulse
   input wire logic       modulation_enable_o, // Modulator allowed
   input wire logic [4:0] block_sel_o,         // Block sent
   input wire logic       init_busy_o          // Initialisation
);
   int init_cnt;
   int prog_cnt;

   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);

   // Length of initialisation and programming phases
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         init_cnt <= 0;
         prog_cnt <= 0;
      end
      else
      begin
         init_cnt <= init_busy_o ? init_cnt + 1 : 0;
         prog_cnt <= program_active_o ? prog_cnt + 1 : 0;
      end
   end

   a_damp_not_prog: assert property (downlink_damp_o |-> !program_active_o)
      else $error("load on while programming");
   a_prog_from_rx: assert property ($rose(program_active_o) |-> $fell(downlink_damp_o))
      else $error("programming not entered from receive");
   a_prog_time: assert property ($fell(program_active_o) |->
      (prog_cnt >= PROG_CYCLES - 1) && (prog_cnt <= PROG_CYCLES + 1))
      else $error("programming length wrong");
   a_rx_not_up: assert property (!(downlink_damp_o && uplink_active_o))
      else $error("receive and uplink together");
   a_start_entry: assert property ($rose(uplink_active_o) |-> ##[0:1] uplink_start_o)
      else $error("no start bit on uplink entry");
   a_start_single: assert property (uplink_start_o |=> !uplink_start_o)
      else $error("start bit longer than one cycle");
   a_mod_in_up: assert property (modulation_enable_o |-> uplink_active_o)
      else $error("modulation outside uplink");
   a_init_quiet: assert property (init_busy_o |->
      !(uplink_active_o || downlink_damp_o || program_active_o))
      else $error("activity during initialisation");
   a_init_len: assert property ($fell(init_busy_o) |-> init_cnt >= INIT_CYCLES - 1)
      else $error("initialisation too short");
   a_sel_hold: assert property (uplink_active_o && $past(uplink_active_o, 2)
      && !$past(next_block_i) && !$past(next_block_i, 2) |-> $stable(block_sel_o))
      else $error("block changed without advance");
endmodule

// >>> tb/tdd_reader.sv
// Base station model sending gap coded frames
`timescale 1ns/1ps
module tdd_reader
(
   output logic field_clk_o = 1'b0, // Field clock, still between frames
   output logic gap_o       = 1'b0, // Field gap
   output logic sync_o      = 1'b0, // Start gap long enough
   output logic active_o    = 1'b0  // Frame in progress
);
   // Field clock of 15 ns runs only during frames
   always
   begin
      #7.5;
      field_clk_o = active_o ? ~field_clk_o : 1'b0;
   end

   // Frame bits MSB first, bit bad gets an illegal carrier length
   task automatic send(input logic [39:0] bits, input int n, input int bad);
      int k;
      active_o = 1'b1;
      repeat (8) @(posedge field_clk_o);
      gap_o <= 1'b1;
      repeat (8) @(posedge field_clk_o);
      sync_o <= 1'b1;
      repeat (8) @(posedge field_clk_o);
      gap_o <= 1'b0;
      sync_o <= 1'b0;
      for (k = n - 1; k >= 0; k--)
      begin
         repeat ((k == bad) ? 40 : (bits[k] ? 56 : 24)) @(posedge field_clk_o);
         gap_o <= 1'b1;
         repeat (8) @(posedge field_clk_o);
         gap_o <= 1'b0;
      end
      repeat (72) @(posedge field_clk_o);
      active_o = 1'b0;
   endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the tag downlink decoder
`timescale 1ns/1ps
module testbench;
   localparam int INIT_N  = 20;
   localparam int DELAY_N = 40;
   localparam int PROG_N  = 30;
   logic        clock_i      = 1'b0;
   logic        rst_i        = 1'b1;
   logic        prog_fault_i = 1'b0;
   logic        next_block_i = 1'b0;
   logic        fclk, gap, sync, rdr_on;
   logic        damp, prog, up, start, mod_en, rate, enc, busy;
   logic [4:0]  sel;
   logic [31:0] data;
   logic        saw_prog, saw_start, saw_damp;
   int          busy_n;
   int          err_count = 0;
   int          compares = 0;

   always #5 clock_i = ~clock_i;

   tdd_reader u_rdr (.field_clk_o(fclk), .gap_o(gap), .sync_o(sync), .active_o(rdr_on));

   tdd_decoder #(.INIT_CYCLES(INIT_N), .DELAY_CYCLES(DELAY_N), .PROG_CYCLES(PROG_N)) u_dut (
      .clock_i(clock_i), .rst_i(rst_i), .field_clk_i(fclk), .gap_detect_i(gap),
      .sync_gap_i(sync), .prog_fault_i(prog_fault_i), .next_block_i(next_block_i),
      .downlink_damp_o(damp), .program_active_o(prog), .uplink_active_o(up),
      .uplink_start_o(start), .modulation_enable_o(mod_en), .block_sel_o(sel),
      .block_data_o(data), .rate_select_flag_o(rate), .encoding_select_flag_o(enc),
      .init_busy_o(busy));

   // Frame builders, opcode first
   function automatic logic [39:0] wr5(input logic lk, input logic [31:0] d, input logic [4:0] a);
      return {2'b11, lk, d, a};
   endfunction
   function automatic logic [39:0] wr3(input logic lk, input logic [31:0] d, input logic [2:0] a);
      return {2'b00, 2'b10, lk, d, a};
   endfunction

   task automatic give_verdict;
      if (err_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Send a frame and wait until the decoder has settled
   task automatic run_cmd(input logic [39:0] bits, input int n, input int bad);
      int k;
      int quiet;
      saw_prog = 1'b0;
      saw_start = 1'b0;
      saw_damp = 1'b0;
      busy_n = 0;
      quiet = 0;
      if (n > 0)
         fork
            u_rdr.send(bits, n, bad);
         join_none
      for (k = 0; k < 10000; k++)
      begin
         @(posedge clock_i);
         #1;
         if (prog === 1'b1) saw_prog = 1'b1;
         if (start === 1'b1) saw_start = 1'b1;
         if (damp === 1'b1) saw_damp = 1'b1;
         if (busy === 1'b1) busy_n++;
         // Settled only after three quiet samples, so verify has moved on
         if (damp === 1'b0 && prog === 1'b0 && busy === 1'b0 && rdr_on === 1'b0)
            quiet++;
         else
            quiet = 0;
         if (quiet == 3) break;
      end
      if (k == 10000)
      begin
         err_count++;
         give_verdict();
      end
      if (n > 0) chk("damp", 1, saw_damp);
   endtask

   task automatic pulse_next(input logic [4:0] exp);
      @(posedge clock_i);
      next_block_i <= 1'b1;
      @(posedge clock_i);
      next_block_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      #1;
      chk("block", 32'(exp), 32'(sel));
   endtask

   initial
   begin
      int i;
      repeat (5) @(posedge clock_i);
      chk("busy", 1, busy);
      rst_i <= 1'b0;
      run_cmd(40'h0, 0, -1);
      chk("init", 1, busy_n >= INIT_N - 1 && busy_n < INIT_N + DELAY_N);
      chk("start", 1, saw_start);
      chk("block", 0, 32'(sel));
      @(posedge clock_i);
      prog_fault_i <= 1'b1;
      run_cmd(wr5(1'b0, 32'h1234_5678, 5'h07), 40, -1);
      @(posedge clock_i);
      prog_fault_i <= 1'b0;
      chk("prog", 1, saw_prog);
      chk("mod", 0, mod_en);
      chk("up", 0, up);
      run_cmd(wr5(1'b0, 32'h5a3c_0f96, 5'h05), 40, -1);
      chk("prog", 1, saw_prog);
      chk("up", 1, up);
      chk("block", 5, 32'(sel));
      chk("data", 32'h5a3c_0f96, data);
      chk("start", 1, saw_start);
      run_cmd({33'h0, 7'h65}, 7, -1);
      chk("prog", 0, saw_prog);
      chk("data", 32'h5a3c_0f96, data);
      pulse_next(5'h05);
      run_cmd(wr3(1'b1, 32'hc0de_0033, 3'h3), 38, -1);
      chk("prog", 1, saw_prog);
      chk("block", 3, 32'(sel));
      run_cmd(wr3(1'b0, 32'h0bad_f00d, 3'h3), 38, -1);
      chk("prog", 0, saw_prog);
      chk("data", 32'hc0de_0033, data);
      for (i = 0; i < 3; i++)
      begin
         case (i)
            0: run_cmd(wr5(1'b0, 32'h0000_ffff, 5'h09), 40, 12);
            1: run_cmd({32'h0, 8'hc5}, 8, -1);
            default: run_cmd({33'h0, 7'h25}, 7, -1);
         endcase
         chk("prog", 0, saw_prog);
         chk("block", 1, 32'(sel));
      end
      run_cmd(wr5(1'b0, 32'h0000_0386, 5'h00), 40, -1);
      run_cmd({32'h0, 8'h00}, 8, -1);
      chk("rate", 1, rate);
      chk("enc", 1, enc);
      chk("mod", 1, mod_en);
      pulse_next(5'h02);
      pulse_next(5'h03);
      pulse_next(5'h01);
      run_cmd(40'h0, 2, -1);
      chk("delay", 1, busy_n >= INIT_N + DELAY_N - 1);
      chk("block", 1, 32'(sel));
      run_cmd(wr5(1'b0, 32'h0000_0040, 5'h00), 40, -1);
      run_cmd({32'h0, 8'h00}, 8, -1);
      chk("up", 1, up);
      chk("mod", 0, mod_en);
      chk("rate", 0, rate);
      give_verdict();
   end
endmodule

bind tdd_decoder tdd_asserts #(.INIT_CYCLES(INIT_CYCLES), .PROG_CYCLES(PROG_CYCLES)) u_chk (
   .clock_i(clock_i), .rst_i(rst_i), .next_block_i(next_block_i),
   .downlink_damp_o(downlink_damp_o), .program_active_o(program_active_o),
   .uplink_active_o(uplink_active_o), .uplink_start_o(uplink_start_o),
   .modulation_enable_o(modulation_enable_o), .block_sel_o(block_sel_o),
   .init_busy_o(init_busy_o));
